// ---- rtl/irt_top.sv ----
// Infrared transceiver host port: register bus, transmitter and receiver
`default_nettype none
`include "irt_cfg.svh"
module irt_top (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       sel,
  input  wire logic       data_en,
  input  wire logic       wr_en,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  input  wire logic       exec,
  input  wire logic       learn,
  output logic            busy,
  output logic            buf_ready,
  output logic            data_err,
  input  wire logic       ir_pulse_in,
  output logic            ir_pulse_out
);
  irt_pkg::irt_state_e state_q;
  irt_pkg::irt_state_e state_d;
  irt_pkg::irt_byte_t  ctrl_q;
  irt_pkg::irt_byte_t  cardiv_q;
  irt_pkg::irt_byte_t  bitlen_q;
  irt_pkg::irt_byte_t  txdata_q;
  irt_pkg::irt_byte_t  rxdata_q;
  irt_pkg::irt_byte_t  shift_q;
  irt_pkg::irt_byte_t  rd_data_q;
  irt_pkg::irt_byte_t  rd_mux;
  irt_pkg::irt_byte_t  slot_q;
  logic [3:0]          bits_q;
  logic                exec_q;
  logic                start;
  logic                wr_acc;
  logic                rd_acc;
  logic                tick;
  logic                phase;
  logic                slot_end;
  logic                seen_q;
  logic                drdy_q;
  logic                err_q;
  logic                out_q;
  logic                rx_done;
  logic                rx_read;

  function automatic logic slot_over(input logic t, input irt_pkg::irt_byte_t cnt,
                                     input irt_pkg::irt_byte_t len);
    slot_over = t && (cnt >= len);
  endfunction

  // ==========================================
  // Bus decode
  // select gates access
  assign wr_acc  = sel && data_en && wr_en;
  assign rd_acc  = sel && data_en && !wr_en;
  assign rx_read = rd_acc && (reg_addr == `IRT_REG_RXDATA);

  // ==========================================
  // Configuration registers
  // single clock domain
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q   <= `IRT_RST_CTRL;
      cardiv_q <= `IRT_RST_CARDIV;
      bitlen_q <= `IRT_RST_BITLEN;
      txdata_q <= `IRT_RST_BYTE;
    end else if (wr_acc) begin
      case (reg_addr)
        `IRT_REG_CTRL:   ctrl_q   <= wr_data;
        `IRT_REG_CARDIV: cardiv_q <= wr_data;
        `IRT_REG_BITLEN: bitlen_q <= wr_data;
        `IRT_REG_TXDATA: txdata_q <= wr_data;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Read path
  always_comb begin
    case (reg_addr)
      `IRT_REG_CTRL:   rd_mux = ctrl_q;
      `IRT_REG_CARDIV: rd_mux = cardiv_q;
      `IRT_REG_BITLEN: rd_mux = bitlen_q;
      `IRT_REG_TXDATA: rd_mux = txdata_q;
      `IRT_REG_RXDATA: rd_mux = rxdata_q;
      `IRT_REG_STATUS: begin
        rd_mux = `IRT_RST_BYTE;
        rd_mux[`IRT_STAT_BUSY] = busy;
        rd_mux[`IRT_STAT_DRDY] = drdy_q;
        rd_mux[`IRT_STAT_ERR]  = err_q;
      end
      default:         rd_mux = `IRT_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data_q <= `IRT_RST_BYTE;
    end else if (rd_acc) begin
      rd_data_q <= rd_mux;
    end
  end
  assign rd_data = rd_data_q;

  // ==========================================
  // Execute edge detect
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= exec;
    end
  end
  assign start = exec && !exec_q;

  // ==========================================
  // Timing
  irt_tick #(
    .DIV_W (8)
  ) u_tick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .restart (state_q == irt_pkg::IRT_IDLE || state_q == irt_pkg::IRT_RX_WAIT),
    .div     (cardiv_q),
    .tick    (tick),
    .phase   (phase)
  );
  assign slot_end = slot_over(tick, slot_q, bitlen_q);

  always_ff @(posedge sys_clk) begin
    if (!resetn || state_q == irt_pkg::IRT_IDLE || state_q == irt_pkg::IRT_RX_WAIT || slot_end) begin
      slot_q <= `IRT_RST_BYTE;
    end else if (tick) begin
      slot_q <= slot_q + 8'h01;
    end
  end

  // ==========================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      irt_pkg::IRT_IDLE: begin
        if (start) begin
          state_d = learn ? irt_pkg::IRT_RX_WAIT : irt_pkg::IRT_TX_START;
        end
      end
      irt_pkg::IRT_TX_START: if (slot_end) state_d = irt_pkg::IRT_TX_BIT;
      irt_pkg::IRT_TX_BIT: begin
        if (slot_end && bits_q == `IRT_DATA_BITS - 4'h1) state_d = irt_pkg::IRT_IDLE;
      end
      irt_pkg::IRT_RX_WAIT: if (ir_pulse_in) state_d = irt_pkg::IRT_RX_START;
      irt_pkg::IRT_RX_START: if (slot_end) state_d = irt_pkg::IRT_RX_BIT;
      irt_pkg::IRT_RX_BIT: begin
        if (slot_end && bits_q == `IRT_DATA_BITS - 4'h1) state_d = irt_pkg::IRT_IDLE;
      end
      default: state_d = irt_pkg::IRT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= irt_pkg::IRT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================
  // Bit counter and shift register
  always_ff @(posedge sys_clk) begin
    if (!resetn || state_q == irt_pkg::IRT_IDLE || state_q == irt_pkg::IRT_RX_WAIT) begin
      bits_q <= 4'h0;
    end else if (slot_end && (state_q == irt_pkg::IRT_TX_BIT || state_q == irt_pkg::IRT_RX_BIT)) begin
      bits_q <= bits_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shift_q <= `IRT_RST_BYTE;
    end else if (state_q == irt_pkg::IRT_IDLE && start) begin
      shift_q <= txdata_q;
    end else if (slot_end && (state_q == irt_pkg::IRT_TX_BIT || state_q == irt_pkg::IRT_RX_BIT)) begin
      shift_q <= {shift_q[6:0], seen_q || ir_pulse_in};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || slot_end || state_q != irt_pkg::IRT_RX_BIT) begin
      seen_q <= 1'b0;
    end else if (ir_pulse_in) begin
      seen_q <= 1'b1;
    end
  end

  // ==========================================
  // Pulse output
  // reset forces off
  always_ff @(posedge sys_clk) begin
    if (!resetn || learn) begin
      out_q <= 1'b0;
    end else if (state_d == irt_pkg::IRT_TX_START) begin
      out_q <= ctrl_q[`IRT_CTRL_MOD_BIT] ? phase : 1'b1;
    end else if (state_d == irt_pkg::IRT_TX_BIT) begin
      out_q <= ((slot_end && state_q == irt_pkg::IRT_TX_BIT) ? shift_q[6] : shift_q[7]) &&
               (ctrl_q[`IRT_CTRL_MOD_BIT] ? phase : 1'b1);
    end else begin
      out_q <= 1'b0;
    end
  end
  assign ir_pulse_out = out_q;

  // ==========================================
  // Receive buffer and status
  assign rx_done = slot_end && state_q == irt_pkg::IRT_RX_BIT && bits_q == `IRT_DATA_BITS - 4'h1;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxdata_q <= `IRT_RST_BYTE;
    end else if (rx_done) begin
      rxdata_q <= {shift_q[6:0], seen_q || ir_pulse_in};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      drdy_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (rx_done) begin
      drdy_q <= 1'b1;
      err_q  <= err_q || drdy_q;
    end else if (rx_read) begin
      drdy_q <= 1'b0;
      err_q  <= 1'b0;
    end
  end

  assign busy      = (state_q != irt_pkg::IRT_IDLE);
  assign buf_ready = drdy_q;
  assign data_err  = err_q;
endmodule
`default_nettype wire

// ---- rtl/irt_cfg.svh ----
// Constants of the infrared transceiver host port
`ifndef IRT_CFG_SVH
`define IRT_CFG_SVH
// ==========================================
// Register offsets
`define IRT_REG_CTRL     4'h0
`define IRT_REG_CARDIV   4'h1
`define IRT_REG_BITLEN   4'h2
`define IRT_REG_TXDATA   4'h3
`define IRT_REG_RXDATA   4'h4
`define IRT_REG_STATUS   4'h5
// ==========================================
// Field positions
`define IRT_CTRL_MOD_BIT 0
`define IRT_STAT_BUSY    0
`define IRT_STAT_DRDY    1
`define IRT_STAT_ERR     2
// ==========================================
// Reset values and data bit count
`define IRT_RST_CTRL     8'h01
`define IRT_RST_CARDIV   8'h0F
`define IRT_RST_BITLEN   8'h10
`define IRT_RST_BYTE     8'h00
`define IRT_DATA_BITS    4'h8
`endif

// ---- rtl/irt_pkg.sv ----
// Types of the infrared transceiver host port
`default_nettype none
package irt_pkg;
  typedef logic [7:0] irt_byte_t;
  typedef enum logic [2:0] {
    IRT_IDLE,
    IRT_TX_START,
    IRT_TX_BIT,
    IRT_RX_WAIT,
    IRT_RX_START,
    IRT_RX_BIT
  } irt_state_e;
endpackage
`default_nettype wire

// ---- rtl/irt_tick.sv ----
// Carrier half-period tick generator of the infrared transceiver
`default_nettype none
module irt_tick #(
  parameter int DIV_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick,
  output logic                  phase
);
  logic [DIV_W-1:0] cnt_q;
  logic             tick_q;
  logic             phase_q;

  // ==========================================
  // Half-period counter
  // carrier tick base
  always_ff @(posedge sys_clk) begin
    if (!resetn || restart) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ==========================================
  // Carrier phase
  always_ff @(posedge sys_clk) begin
    if (!resetn || restart) begin
      phase_q <= 1'b1;
    end else if (cnt_q >= div) begin
      phase_q <= ~phase_q;
    end
  end

  assign tick  = tick_q;
  assign phase = phase_q;
endmodule
`default_nettype wire

// ---- verification/irt_top_asserts.sv ----
// Checker of the infrared transceiver host port
`default_nettype none
module irt_top_asserts (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       sel,
  input wire logic       data_en,
  input wire logic       wr_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       exec,
  input wire logic       learn,
  input wire logic       busy,
  input wire logic       buf_ready,
  input wire logic       data_err,
  input wire logic       ir_pulse_in,
  input wire logic       ir_pulse_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic rd_go = sel && data_en && !wr_en;
  // ==========================================
  // Assertions
  a_reset_clears_all: assert property ($rose(resetn) |-> !busy && !buf_ready && !data_err && !ir_pulse_out)
    else $error("outputs not cleared by reset");
  a_exec_starts_busy: assert property (exec && !$past(exec) && !busy |=> busy)
    else $error("exec edge did not start operation");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(exec) && !$past(busy))
    else $error("busy rose without exec");
  a_learn_out_low: assert property (learn |=> !ir_pulse_out)
    else $error("pulse output on in learn mode");
  a_idle_out_off: assert property (!busy && !$past(busy) |-> !ir_pulse_out)
    else $error("pulse output on while idle");
  a_rdata_holds: assert property (!rd_go |=> $stable(rd_data))
    else $error("read data changed without read");
  a_status_read: assert property (rd_go && reg_addr == 4'h5 |=>
      rd_data == {5'h00, $past(data_err), $past(buf_ready), $past(busy)})
    else $error("status read wrong");
  a_unmapped_zero: assert property (rd_go && reg_addr > 4'h5 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_err_overrun: assert property ($rose(data_err) |-> $past(buf_ready))
    else $error("error without pending byte");
  a_read_clears: assert property (rd_go && reg_addr == 4'h4 && !busy |=> !buf_ready && !data_err)
    else $error("data read did not clear flags");
  c_rx_done: cover property ($rose(buf_ready));
  c_overrun: cover property ($rose(data_err));
  c_tx_end: cover property ($fell(busy) && !learn);
endmodule
bind irt_top irt_top_asserts chk_i (.sys_clk, .resetn, .sel, .data_en, .wr_en, .reg_addr, .wr_data, .rd_data,
  .exec, .learn, .busy, .buf_ready, .data_err, .ir_pulse_in, .ir_pulse_out);
`default_nettype wire

// ---- verification/irt_emitter.sv ----
// Sensor model that sends one framed byte on the pulse input
`default_nettype none
module irt_emitter #(
  parameter int SLOT = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       send,
  input  wire logic [7:0] data,
  output var  logic       ir_pulse_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] frame_q;
  initial begin
    ir_pulse_in = 1'b0;
    forever begin
      @(posedge send);
      frame_q = {1'b1, data};
      for (int i = 8; i >= 0; i--) begin
        repeat (SLOT) @(negedge sys_clk) ir_pulse_in = frame_q[i];
      end
      @(negedge sys_clk) ir_pulse_in = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench of the infrared transceiver host port
`default_nettype none
`include "irt_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       sel = 1'b0;
  logic       data_en = 1'b0;
  logic       wr_en = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic       exec = 1'b0;
  logic       learn = 1'b0;
  logic       send = 1'b0;
  logic       ir_pulse_in;
  logic [7:0] rd_data;
  logic       busy, buf_ready, data_err, ir_pulse_out;
  int         failures = 0;
  int         n_tests = 0;
  int         cycles = 0;
  always #2 sys_clk = ~sys_clk;
  irt_top dut (.sys_clk, .resetn, .sel, .data_en, .wr_en, .reg_addr, .wr_data, .rd_data, .exec, .learn,
    .busy, .buf_ready, .data_err, .ir_pulse_in, .ir_pulse_out);
  irt_emitter #(.SLOT(8)) emit (.sys_clk, .send, .data(8'hF0), .ir_pulse_in);
  // ==========================================
  // Shared tasks
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic s, input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {sel, data_en, wr_en, reg_addr, wr_data} = {s, 1'b1, w, a, d};
    @(negedge sys_clk);
    {sel, data_en, wr_en} = 3'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b1, 1'b0, a, 8'h00);
    chk("rd_data", rd_data, exp);
  endtask
  task automatic go(input logic l, output int rises);
    logic prev;
    int   n;
    prev = 1'b0;
    n = 0;
    rises = 0;
    repeat (16) @(negedge sys_clk);
    learn = l;
    exec = 1'b1;
    send = l;
    @(negedge sys_clk);
    exec = 1'b0;
    send = 1'b0;
    @(negedge sys_clk);
    chk("busy", {7'h00, busy}, 8'h01);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge sys_clk);
      rises += (ir_pulse_out === 1'b1 && prev === 1'b0);
      prev = ir_pulse_out;
      n++;
    end
    chk("idle", {7'h00, busy}, 8'h00);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] exp [6] = '{`IRT_RST_CTRL, `IRT_RST_CARDIV, `IRT_RST_BITLEN, `IRT_RST_BYTE, `IRT_RST_BYTE, 8'h00};
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], a < 6 ? exp[a] : 8'h00);
    end
  endtask
  task automatic t_regs;
    bus(1'b1, 1'b1, `IRT_REG_TXDATA, 8'h3C);
    bus(1'b0, 1'b1, `IRT_REG_TXDATA, 8'hFF);
    bus(1'b1, 1'b1, `IRT_REG_STATUS, 8'hFF);
    rd(`IRT_REG_TXDATA, 8'h3C);
    rd(`IRT_REG_STATUS, 8'h00);
    bus(1'b1, 1'b1, `IRT_REG_CARDIV, 8'h01);
    bus(1'b1, 1'b1, `IRT_REG_BITLEN, 8'h03);
    rd(`IRT_REG_BITLEN, 8'h03);
  endtask
  task automatic t_tx;
    int r;
    bus(1'b1, 1'b1, `IRT_REG_TXDATA, 8'hA5);
    bus(1'b1, 1'b1, `IRT_REG_CTRL, 8'h00);
    go(1'b0, r);
    chk("steady rises", r[7:0], 8'h04);
    bus(1'b1, 1'b1, `IRT_REG_CTRL, 8'h01);
    go(1'b0, r);
    chk("carrier", {7'h00, r > 4}, 8'h01);
  endtask
  task automatic t_rx;
    int r;
    go(1'b1, r);
    chk("quiet", r[7:0], 8'h00);
    chk("ready", {7'h00, buf_ready}, 8'h01);
    rd(`IRT_REG_RXDATA, 8'hF0);
    rd(`IRT_REG_STATUS, 8'h00);
    go(1'b1, r);
    go(1'b1, r);
    chk("err", {7'h00, data_err}, 8'h01);
    rd(`IRT_REG_STATUS, 8'h06);
    rd(`IRT_REG_RXDATA, 8'hF0);
    rd(`IRT_REG_STATUS, 8'h00);
  endtask
  task automatic t_midrst;
    bus(1'b1, 1'b1, `IRT_REG_TXDATA, 8'hFF);
    bus(1'b1, 1'b1, `IRT_REG_CTRL, 8'h00);
    learn = 1'b0;
    exec = 1'b1;
    repeat (12) @(negedge sys_clk);
    chk("tx on", {6'h00, busy, ir_pulse_out}, 8'h03);
    resetn = 1'b0;
    exec = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("reset outs", {4'h0, busy, buf_ready, data_err, ir_pulse_out}, 8'h00);
    resetn = 1'b1;
    t_reset();
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    t_reset();
    t_regs();
    t_tx();
    t_rx();
    t_midrst();
    print_verdict();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
endmodule
`default_nettype wire
